// ===== hw/sep_device.sv
// Memory device end: decoder, enable latch, array, program timer
`timescale 1ns/1ps
module sep_device
    import sep_pkg::*;
#(
    parameter int PROG_CNT = PROG_CYCLES
) (
    input  wire logic clk,
    input  wire logic reset_n,
    sep_link_if.device link,
    input  wire logic wordWidthStrap,
    input  wire logic supplyLow,
    output logic      busy
);
    logic csLvl, csRise, csFall;
    logic skRise, skFall;
    logic diLvl;
    logic orgLvl, lowLvl;
    sep_sync2 uCs (.clk(clk), .reset_n(reset_n), .async(link.chipSelect),
        .level(csLvl), .rise(csRise), .fall(csFall));
    sep_sync2 uSk (.clk(clk), .reset_n(reset_n), .async(link.serialClock),
        .level(), .rise(skRise), .fall(skFall));
    sep_sync2 uDi (.clk(clk), .reset_n(reset_n), .async(link.serialIn),
        .level(diLvl), .rise(), .fall());
    sep_sync2 uOrg (.clk(clk), .reset_n(reset_n), .async(wordWidthStrap),
        .level(orgLvl), .rise(), .fall());
    sep_sync2 uLow (.clk(clk), .reset_n(reset_n), .async(supplyLow),
        .level(lowLvl), .rise(), .fall());

    logic [7:0]  mem [ARRAY_BYTES];
    sep_state_t  state_r, state_nxt;
    logic [1:0]  opc_r;
    logic [8:0]  addr_r;
    logic [15:0] data_r;
    logic [4:0]  cnt_r;
    logic        unlock_r;
    logic        pend_r;
    logic [1:0]  pendKind_r;
    logic        prog_r;
    logic [23:0] timer_r;
    logic [8:0]  wipe_r;
    logic        statusOn_r;
    logic        out_r, outEn_r, busy_r;
    logic [15:0] shift_r;

    wire        wide     = orgLvl;                           // see RL1
    wire [4:0]  addrLen  = wide ? 5'(ADDR_W16) : 5'(ADDR_W8); // see RL2
    wire [4:0]  dataLen  = wide ? 5'(DATA_W16) : 5'(DATA_W8);
    wire [8:0]  addrNew  = {addr_r[7:0], diLvl};
    wire [1:0]  extCode  = wide ? addrNew[7:6] : addrNew[8:7]; // see RL4
    wire        bitTake  = csLvl && skRise;                  // see RL5
    wire        lastBit  = (cnt_r == 5'(1));
    wire        needData = (opc_r == OP_WRITE) ||
                           (opc_r == OP_EXT && extCode == EX_FILL);
    wire [8:0]  byteIdx  = wide ? {addrNew[7:0], 1'b0} : addrNew;
    wire [15:0] rdWord   = wide ? {mem[byteIdx], mem[byteIdx | 9'h1]}
                                : {mem[byteIdx], 8'h00};
    wire        progDone = prog_r && timer_r == 24'(PROG_CNT - 1);
    wire [8:0]  wrIdx    = wide ? {wipe_r[7:0], 1'b0} : wipe_r;
    // Fill ends in the data phase, so its extension comes from the register
    wire [1:0]  extHeld  = wide ? addr_r[7:6] : addr_r[8:7];
    wire [1:0]  extNow   = (state_r == SEP_ADR) ? extCode : extHeld;
    wire        rdStart  = bitTake && state_r == SEP_ADR && lastBit &&
                           opc_r == OP_READ;

    always_comb begin
        state_nxt = state_r;
        if (!csLvl || prog_r) begin
            state_nxt = SEP_IDLE;                            // see RL21
        end else if (bitTake) begin
            case (state_r)
                SEP_IDLE: if (diLvl) state_nxt = SEP_OPC;    // see RL21
                SEP_OPC:  if (lastBit) state_nxt = SEP_ADR;
                SEP_ADR:  if (lastBit) begin
                    if (opc_r == OP_READ) state_nxt = SEP_RD; // see RL3
                    else if (needData) state_nxt = SEP_DAT;
                    else state_nxt = SEP_DONE;
                end
                SEP_DAT:  if (lastBit) state_nxt = SEP_DONE;
                SEP_RD:   if (lastBit) state_nxt = SEP_DONE;
                SEP_DONE: state_nxt = SEP_DONE;
                default:  state_nxt = SEP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            state_r <= SEP_IDLE;
            opc_r   <= 2'h0;
            addr_r  <= 9'h0;
            data_r  <= 16'h0;
            cnt_r   <= 5'h0;
            shift_r <= 16'h0;
        end else begin
            state_r <= state_nxt;
            if (bitTake) begin
                case (state_r)
                    SEP_IDLE: cnt_r <= 5'(2);
                    SEP_OPC: begin
                        opc_r <= {opc_r[0], diLvl};
                        cnt_r <= lastBit ? addrLen : cnt_r - 5'(1);
                        addr_r <= 9'h0;
                    end
                    SEP_ADR: begin
                        addr_r <= addrNew;
                        cnt_r  <= lastBit ? (opc_r == OP_READ ? 5'(dataLen + 5'(1))
                                  : dataLen) : cnt_r - 5'(1);
                        if (lastBit) shift_r <= rdWord;     // see RL14
                    end
                    SEP_DAT: begin
                        data_r <= {data_r[14:0], diLvl};
                        cnt_r  <= cnt_r - 5'(1);
                    end
                    SEP_RD: begin
                        cnt_r   <= cnt_r - 5'(1);
                        shift_r <= {shift_r[14:0], 1'b0};
                    end
                    default: cnt_r <= cnt_r;
                endcase
            end
        end
    end

    // Programming control, timer and array
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            unlock_r   <= 1'b0;                              // see RL12
            pend_r     <= 1'b0;
            pendKind_r <= 2'h0;
            prog_r     <= 1'b0;
            timer_r    <= 24'h0;
            wipe_r     <= 9'h0;
        end else begin
            if (lowLvl) begin
                unlock_r <= 1'b0;                            // see RL10
                pend_r   <= 1'b0;
            end else if (bitTake && state_r == SEP_ADR && lastBit &&
                         opc_r == OP_EXT) begin
                if (extCode == EX_UNLOCK) unlock_r <= 1'b1;  // see RL13
                if (extCode == EX_LOCK) unlock_r <= 1'b0;
            end
            if (state_nxt == SEP_DONE && state_r != SEP_DONE && !lowLvl &&
                unlock_r && opc_r != OP_READ &&
                !(opc_r == OP_EXT && extNow[0] == extNow[1])) begin
                pend_r     <= 1'b1;                          // see RL12
                pendKind_r <= opc_r;
            end
            if (csFall && pend_r && !lowLvl) begin
                pend_r  <= 1'b0;
                prog_r  <= 1'b1;                             // see RL15
                timer_r <= 24'h0;
                wipe_r  <= 9'h0;
            end else if (!csLvl && !pend_r) begin
                pend_r <= 1'b0;
            end
            if (csRise) pend_r <= 1'b0;
            if (prog_r) begin
                timer_r <= timer_r + 24'(1);                 // see RL22
                if (progDone) prog_r <= 1'b0;
                if (wipe_r != 9'h1FF) wipe_r <= wipe_r + 9'(1);
            end
        end
    end

    wire allLoc  = pendKind_r == OP_EXT;
    logic clrAll_r;
    always_ff @(posedge clk) begin
        if (!reset_n) clrAll_r <= 1'b0;
        else if (csFall && pend_r) clrAll_r <= (addr_r[8:7] == EX_CLEAR &&
            !wide) || (addr_r[7:6] == EX_CLEAR && wide);
    end
    wire eraseOp = (pendKind_r == OP_ERASE) || (allLoc && clrAll_r);
    wire [15:0] wrWord = eraseOp ? {ERASED_BYTE, ERASED_BYTE} : data_r;

    always_ff @(posedge clk) begin
        if (prog_r && timer_r == 24'h0 && !allLoc) begin     // see RL18
            if (wide) begin
                mem[{addr_r[7:0], 1'b0}] <= wrWord[15:8];   // see RL17
                mem[{addr_r[7:0], 1'b1}] <= wrWord[7:0];    // see RL16
            end else begin
                mem[addr_r] <= wrWord[7:0];
            end
        end else if (prog_r && allLoc && timer_r <= 24'(ARRAY_BYTES)) begin
            if (wide) begin
                mem[wrIdx]        <= wrWord[15:8];           // see RL19
                mem[wrIdx | 9'h1] <= wrWord[7:0];            // see RL20
            end else begin
                mem[wipe_r] <= wrWord[7:0];
            end
        end
    end

    // Serial output: read data, then status after programming
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            out_r      <= 1'b0;
            outEn_r    <= 1'b0;
            statusOn_r <= 1'b0;
            busy_r     <= 1'b0;
        end else begin
            busy_r <= prog_r;
            if (csFall && pend_r) statusOn_r <= 1'b1;
            else if (csLvl && state_r == SEP_IDLE && bitTake && diLvl &&
                     !prog_r) statusOn_r <= 1'b0;            // see RL8
            if (!csLvl) begin
                outEn_r <= 1'b0;                             // see RL6
            end else if (rdStart) begin
                outEn_r <= 1'b1;
                out_r   <= 1'b0;                             // see RL11
            end else if (state_r == SEP_RD) begin
                outEn_r <= 1'b1;
                if (bitTake && !lastBit) out_r <= shift_r[15]; // see RL11
            end else if (statusOn_r) begin
                outEn_r <= 1'b1;
                out_r   <= ~prog_r;                          // see RL7
            end else if (skFall) begin
                outEn_r <= 1'b0;                             // see RL8
            end
        end
    end

    assign link.serialOut   = out_r;
    assign link.serialOutEn = outEn_r;
    assign busy             = busy_r;
endmodule // sep_device

// ===== hw/sep_host.sv
// Host end: frames one instruction per request on the serial link
`timescale 1ns/1ps
module sep_host
    import sep_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        reset_n,
    sep_link_if.host         link,
    input  wire logic        cmdValid,
    input  wire logic [1:0]  cmdOp,
    input  wire logic [8:0]  cmdAddr,
    input  wire logic [15:0] cmdData,
    input  wire logic        cmdWide,
    output logic             cmdReady,
    output logic [15:0]      rdData,
    output logic             rdValid
);
    logic        doLvl;
    sep_sync2 uDo (.clk(clk), .reset_n(reset_n), .async(link.serialOut),
        .level(doLvl), .rise(), .fall());
    logic [27:0] frame_r;
    logic [4:0]  left_r, rdLeft_r;
    logic [7:0]  div_r;
    logic        cs_r, sk_r, di_r, rdy_r, rv_r, rdMode_r;
    logic [15:0] rd_r;
    logic [15:0] low_r;
    wire  [4:0]  aLen = cmdWide ? 5'(ADDR_W16) : 5'(ADDR_W8);
    wire  [4:0]  dLen = cmdWide ? 5'(DATA_W16) : 5'(DATA_W8);
    wire         hasD = cmdOp == OP_WRITE || (cmdOp == OP_EXT &&
                        (cmdWide ? cmdAddr[7:6] : cmdAddr[8:7]) == EX_FILL);
    wire         isRd = cmdOp == OP_READ;
    wire  [4:0]  fLen = 5'(3) + aLen + (hasD ? dLen : 5'h0);
    // Frame is MSB-aligned: start, opcode, address, data
    wire  [27:0] fImg = cmdWide ?
                        {1'b1, cmdOp, cmdAddr[7:0], cmdData, 1'b0} :
                        {1'b1, cmdOp, cmdAddr, cmdData[7:0], 8'h00};
    wire         tick = div_r == 8'(LINK_HALF - 1);
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            cs_r <= 1'b0; sk_r <= 1'b0; di_r <= 1'b0; rdy_r <= 1'b1;
            rv_r <= 1'b0; rd_r <= 16'h0; frame_r <= 28'h0; left_r <= 5'h0;
            rdLeft_r <= 5'h0; div_r <= 8'h0; low_r <= 16'h0;
            rdMode_r <= 1'b0;
        end else begin
            rv_r  <= 1'b0;
            div_r <= tick ? 8'h0 : div_r + 8'(1);
            if (rdy_r && cmdValid) begin
                rdy_r    <= 1'b0;
                cs_r     <= 1'b1;                            // see RL2
                di_r     <= fImg[27];
                frame_r  <= {fImg[26:0], 1'b0};
                rdMode_r <= isRd;
                left_r   <= fLen;
                rdLeft_r <= isRd ? dLen + 5'(1) : 5'h0;
                div_r    <= 8'h0;
            end else if (!rdy_r && tick) begin
                if (low_r != 16'h0) begin
                    low_r <= low_r - 16'(1);                 // see RL15
                    if (low_r == 16'(1)) rdy_r <= 1'b1;
                end else if (!sk_r && (left_r != 0 || rdLeft_r != 0)) begin
                    sk_r <= 1'b1;                            // see RL5
                    if (left_r == 0) begin
                        rd_r     <= {rd_r[14:0], doLvl};
                        rdLeft_r <= rdLeft_r - 5'(1);
                    end
                end else if (sk_r) begin
                    sk_r <= 1'b0;
                    if (left_r != 0) begin
                        di_r    <= frame_r[27];
                        frame_r <= {frame_r[26:0], 1'b0};
                        left_r  <= left_r - 5'(1);
                    end
                end else begin
                    cs_r  <= 1'b0;                           // see RL9
                    di_r  <= 1'b0;
                    rv_r  <= rdMode_r;
                    low_r <= 16'(DESEL_CYCLES / LINK_HALF + 1); // see RL17
                end
            end
        end
    end
    assign link.chipSelect  = cs_r;
    assign link.serialClock = sk_r;
    assign link.serialIn    = di_r;
    assign cmdReady = rdy_r;
    assign rdData   = rd_r;
    assign rdValid  = rv_r;
endmodule // sep_host

// ===== hw/sep_link_if.sv
// Serial link between host and memory device
`timescale 1ns/1ps
interface sep_link_if;
    logic chipSelect;
    logic serialClock;
    logic serialIn;
    logic serialOut;
    logic serialOutEn;
    modport device (
        input  chipSelect,
        input  serialClock,
        input  serialIn,
        output serialOut,
        output serialOutEn
    );
    modport host (
        output chipSelect,
        output serialClock,
        output serialIn,
        input  serialOut,
        input  serialOutEn
    );
endinterface

// ===== hw/sep_pkg.sv
// Shared constants and types for the serial memory command port
// Behaviour
// RL1: Strap high or open gives 256x16, low 512x8
// RL2: Frame: start one, opcode, address, optional data
// RL3: Opcode 10 read, 11 erase, 01 write
// RL4: Opcode 00 extension: unlock, lock, clear, fill
// RL5: Input sampled on rising serial clock edges
// RL6: Output floats except read data or status
// RL7: Status low while busy, high when done
// RL8: Shifting a one releases status on falling edge
// RL9: Host floats device output before driving shared wire
// RL10: Supply low blocks programming and locks
// RL11: Read emits leading zero then word, rising edges
// RL12: Programming ignored unless unlocked since power-up
// RL13: Unlock persists until lock or power loss
// RL14: Reads work whether locked or unlocked
// RL15: Erase starts at select fall, self-timed
// RL16: Erased bits read back as one
// RL17: Write erases then stores at select fall
// RL18: Word write needs no separate erase
// RL19: Clear-all erases every location at select fall
// RL20: Fill-all writes word everywhere at select fall
// RL21: Deselected resets decoder; leading zeros are idle
// RL22: Program cycle within 10 ms, busy throughout
package sep_pkg;
    localparam int  CLK_HZ        = 20_000_000;
    localparam int  PROG_TIME_US  = 10_000;
    localparam int  PROG_CYCLES   = PROG_TIME_US * (CLK_HZ / 1_000_000);
    localparam int  DESEL_TIME_NS = 1_000;
    localparam int  CLK_NS        = 50;
    localparam int  DESEL_CYCLES  = (DESEL_TIME_NS + CLK_NS - 1) / CLK_NS;
    localparam int  LINK_HALF     = 5;
    localparam int  ARRAY_BYTES   = 512;
    localparam int  ADDR_W16      = 8;
    localparam int  ADDR_W8       = 9;
    localparam int  DATA_W16      = 16;
    localparam int  DATA_W8       = 8;
    localparam logic [1:0] OP_EXT   = 2'h0;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] OP_READ  = 2'h2;
    localparam logic [1:0] OP_ERASE = 2'h3;
    localparam logic [1:0] EX_LOCK   = 2'h0;
    localparam logic [1:0] EX_FILL   = 2'h1;
    localparam logic [1:0] EX_CLEAR  = 2'h2;
    localparam logic [1:0] EX_UNLOCK = 2'h3;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    typedef enum logic [2:0] {
        SEP_IDLE = 3'h0,
        SEP_OPC  = 3'h1,
        SEP_ADR  = 3'h3,
        SEP_DAT  = 3'h2,
        SEP_RD   = 3'h6,
        SEP_DONE = 3'h7
    } sep_state_t;
endpackage

// ===== hw/sep_sync2.sv
// Two-flop synchroniser with edge flags taken after the second flop
`timescale 1ns/1ps
module sep_sync2 (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic async,
    output logic      level,
    output logic      rise,
    output logic      fall
);
    logic meta_r;
    logic sync_r;
    logic last_r;
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            meta_r <= 1'b0;
            sync_r <= 1'b0;
            last_r <= 1'b0;
        end else begin
            meta_r <= async;
            sync_r <= meta_r;
            last_r <= sync_r;
        end
    end
    assign level = sync_r;
    assign rise  = sync_r & ~last_r;
    assign fall  = ~sync_r & last_r;
endmodule // sep_sync2

// ===== verification/sep_chk_sva.sv
// Checker for link timing, status output and program cycle length
`timescale 1ns/1ps
module sep_chk_sva
    import sep_pkg::*;
#(
    parameter int PROG_CNT = PROG_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic chipSelect,
    input wire logic serialClock,
    input wire logic serialIn,
    input wire logic serialOut,
    input wire logic serialOutEn,
    input wire logic busy
);
    logic [19:0] busyCnt_r;
    logic [19:0] busyCnt_nxt;
    logic [5:0]  lowCnt_r;
    logic [5:0]  lowCnt_nxt;

    // Low-time counter saturates so long idle gaps never wrap
    assign busyCnt_nxt = busy ? busyCnt_r + 20'h1 : 20'h0;
    assign lowCnt_nxt  = chipSelect ? 6'h0 :
                         (lowCnt_r == 6'h3F) ? lowCnt_r : lowCnt_r + 6'h1;

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            busyCnt_r <= 20'h0;
            lowCnt_r  <= 6'h3F;
        end else begin
            busyCnt_r <= busyCnt_nxt;
            lowCnt_r  <= lowCnt_nxt;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!reset_n);

    AST_OE_IDLE: assert property (
        (!chipSelect) [*5] |-> !serialOutEn)
        else $error("output driven while deselected");
    AST_DI_HOLD: assert property (
        $rose(serialClock) && chipSelect |-> $stable(serialIn))
        else $error("serial input moved at clock rise");
    AST_SK_HIGH: assert property (
        $rose(serialClock) |-> serialClock [*5])
        else $error("serial clock high phase too short");
    AST_OE_REL: assert property (
        $fell(serialOutEn) |-> !serialClock)
        else $error("output released outside clock low phase");
    AST_STATUS_BUSY: assert property (
        busy && $past(busy, 4) && serialOutEn |-> !serialOut)
        else $error("status not low while busy");
    AST_BUSY_START: assert property (
        $rose(busy) |-> !chipSelect)
        else $error("program cycle began while selected");
    AST_BUSY_MAX: assert property (
        busy |-> int'(busyCnt_r) < PROG_CNT + 2)
        else $error("program cycle too long");
    AST_BUSY_MIN: assert property (
        $fell(busy) |-> int'(busyCnt_r) >= PROG_CNT - 2)
        else $error("program cycle too short");
    AST_CS_GAP: assert property (
        $rose(chipSelect) |-> int'(lowCnt_r) >= DESEL_CYCLES)
        else $error("deselect gap too short");

    cover property ($rose(busy));
    cover property (busy && serialOutEn);
    cover property ($fell(serialOutEn) && chipSelect);
endmodule // sep_chk_sva

// ===== verification/testbench.sv
// Self-checking bench joining host and device ends over the link
`timescale 1ns/1ps
module testbench;
    import sep_pkg::*;
    localparam int PCNT = 600;
    logic        clk;
    logic        reset_n;
    logic        cmdValid;
    logic        cmdWide;
    logic        cmdReady;
    logic        rdValid;
    logic        wordWidthStrap;
    logic        supplyLow;
    logic        busy;
    logic [1:0]  cmdOp;
    logic [8:0]  cmdAddr;
    logic [15:0] cmdData;
    logic [15:0] rdData;
    int          errors;
    int          cmp_count;

    sep_link_if link ();
    sep_host i_sep_host (.clk, .reset_n, .link, .cmdValid, .cmdOp, .cmdAddr,
        .cmdData, .cmdWide, .cmdReady, .rdData, .rdValid);
    sep_device #(.PROG_CNT(PCNT)) i_sep_device (.clk, .reset_n, .link,
        .wordWidthStrap, .supplyLow, .busy);
    sep_chk_sva #(.PROG_CNT(PCNT)) i_sep_chk_sva (.clk, .reset_n,
        .chipSelect(link.chipSelect), .serialClock(link.serialClock),
        .serialIn(link.serialIn), .serialOut(link.serialOut),
        .serialOutEn(link.serialOutEn), .busy);

    task automatic complete_run();
        $display("errors %0d comparisons %0d", errors, cmp_count);
        if (errors == 0 && cmp_count > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic chk(input bit ok, input string msg);
        cmp_count++;
        if (!ok) begin
            errors++;
            $display("ERROR %0t %s", $time, msg);
        end
    endtask

    function automatic bit cond(input int w);
        case (w)
            0: return cmdReady === 1'b1;
            1: return cmdReady === 1'b1 && busy === 1'b0;
            default: return rdValid === 1'b1;
        endcase
    endfunction

    // Waits at falling edges so registered outputs have settled
    task automatic wait_on(input int w);
        int n;
        n = 0;
        @(negedge clk);
        while (!cond(w)) begin
            n++;
            if (n > 3000) begin
                chk(1'b0, "wait timed out");
                complete_run();
            end
            @(negedge clk);
        end
    endtask

    task automatic send(input logic [1:0] op, input logic [8:0] a,
                        input logic [15:0] d);
        wait_on(0);
        @(posedge clk);
        cmdValid <= 1'b1;
        cmdOp    <= op;
        cmdAddr  <= a;
        cmdData  <= d;
        @(posedge clk);
        cmdValid <= 1'b0;
    endtask

    // Busy is judged once the deselect gap has passed
    task automatic prog(input logic [1:0] op, input logic [8:0] a,
                        input logic [15:0] d, input logic expBusy);
        send(op, a, d);
        wait_on(0);
        chk(busy === expBusy, "busy after command");
        wait_on(1);
    endtask

    task automatic rd(input logic [8:0] a, input logic [15:0] exp);
        send(OP_READ, a, 16'h0000);
        wait_on(2);
        chk((cmdWide ? rdData : {8'h00, rdData[7:0]}) === exp, "read data");
    endtask

    function automatic logic [8:0] ex(input logic [1:0] e);
        return cmdWide ? {1'b0, e, 6'h00} : {e, 7'h00};
    endfunction

    task automatic t_clear();
        prog(OP_EXT, ex(EX_UNLOCK), 16'h0000, 1'b0);
        prog(OP_EXT, ex(EX_CLEAR), 16'h0000, 1'b1);
        rd(9'h005, {2{ERASED_BYTE}});
        rd(9'h0FF, {2{ERASED_BYTE}});
    endtask

    task automatic t_locked();
        prog(OP_EXT, ex(EX_LOCK), 16'h0000, 1'b0);
        prog(OP_WRITE, 9'h005, 16'h1234, 1'b0);
        prog(OP_EXT, ex(EX_FILL), 16'h0000, 1'b0);
        rd(9'h005, {2{ERASED_BYTE}});
    endtask

    task automatic t_write();
        prog(OP_EXT, ex(EX_UNLOCK), 16'h0000, 1'b0);
        prog(OP_WRITE, 9'h005, 16'h1234, 1'b1);
        prog(OP_WRITE, 9'h005, 16'hEDCB, 1'b1);
        rd(9'h005, 16'hEDCB);
        rd(9'h006, {2{ERASED_BYTE}});
        prog(OP_ERASE, 9'h005, 16'h0000, 1'b1);
        rd(9'h005, {2{ERASED_BYTE}});
    endtask

    task automatic t_fill_narrow();
        prog(OP_EXT, ex(EX_FILL), 16'h5A5A, 1'b1);
        rd(9'h000, 16'h5A5A);
        @(posedge clk);
        wordWidthStrap <= 1'b0;
        cmdWide        <= 1'b0;
        prog(OP_WRITE, 9'h1FF, 16'h003C, 1'b1);
        rd(9'h1FF, 16'h003C);
        rd(9'h1FE, 16'h005A);
        @(posedge clk);
        wordWidthStrap <= 1'b1;
        cmdWide        <= 1'b1;
        rd(9'h0FF, 16'h5A3C);
    endtask

    // A read sent mid-cycle sees low status, then is released
    task automatic t_busy();
        send(OP_WRITE, 9'h007, 16'h0F0F);
        wait_on(0);
        send(OP_READ, 9'h007, 16'h0000);
        wait_on(2);
        chk(busy === 1'b1, "busy ended early");
        chk(rdData === 16'h0000, "status not low while busy");
        wait_on(1);
        chk(link.serialOutEn === 1'b0, "output left driven");
        rd(9'h007, 16'h0F0F);
    endtask

    task automatic t_supply();
        @(posedge clk);
        supplyLow <= 1'b1;
        repeat (8) @(posedge clk);
        supplyLow <= 1'b0;
        prog(OP_WRITE, 9'h007, 16'h0000, 1'b0);
        rd(9'h007, 16'h0F0F);
    endtask

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    initial begin
        reset_n        = 1'b0;
        cmdValid       = 1'b0;
        cmdOp          = 2'h0;
        cmdAddr        = 9'h000;
        cmdData        = 16'h0000;
        cmdWide        = 1'b1;
        wordWidthStrap = 1'b1;
        supplyLow      = 1'b0;
        errors         = 0;
        cmp_count      = 0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_clear();
        t_locked();
        t_write();
        t_fill_narrow();
        t_busy();
        t_supply();
        complete_run();
    end
endmodule // testbench
